// >>> pot_regs.svh
// constants for the two-wire slave of the dual potentiometer
// assumes a 10 MHz system clock; included by the package only
`ifndef POT_REGS_SVH
`define POT_REGS_SVH

// -----------------------------------------------------------------
// byte layout
// -----------------------------------------------------------------
`define BYTE_BITS 8
`define ADDR_TYPE_HI 7
`define ADDR_TYPE_LO 4
`define ADDR_STRAP_HI 3
`define ADDR_STRAP_LO 0
`define INSTR_OP_HI 7
`define INSTR_OP_LO 4
`define INSTR_WIPER_BIT 2
`define INSTR_REG_HI 1
`define INSTR_REG_LO 0

// -----------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------
`define OP_RD_WCR 4'h9
`define OP_WR_WCR 4'hA
`define OP_RD_DR 4'hB
`define OP_WR_DR 4'hC
`define OP_XFR_D2W 4'hD
`define OP_XFR_W2D 4'hE
`define OP_GXFR_D2W 4'h1
`define OP_GXFR_W2D 4'h8
`define OP_INCDEC 4'h2

// -----------------------------------------------------------------
// timing and sizes
// -----------------------------------------------------------------
`define CLK_FREQ_KHZ 10000
`define T_WR_MS 5
`define WR_CYCLES (`T_WR_MS * `CLK_FREQ_KHZ)
`define WR_CNT_BITS 16
`define CMD_FIFO_DEPTH 8

`endif

// >>> pot_pkg.sv
// types shared by the potentiometer serial slave and its helpers
// assumes pot_regs.svh is on the include path
`include "pot_regs.svh"

package pot_pkg;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INSTR,
        ST_INSTR_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT_STOP,
        ST_NV_BUSY
    } state_e;

    typedef struct packed {
        logic [3:0] opcode;
        logic wiperSelectBit;
        logic dataRegSelectHi;
        logic dataRegSelectLo;
        logic hasData;
        logic [7:0] data;
    } cmd_s;

    typedef struct packed {
        logic start;
        logic stop;
        logic sclRise;
        logic sclFall;
        logic sda;
    } line_s;

endpackage

// >>> line_sync.sv
// synchronises the serial clock and data pins and flags bus events
// assumes pins are asynchronous and slow next to clk
`timescale 1ns/1ns
`default_nettype none

module line_sync
    import pot_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output line_s events
);

    logic sclMeta_q;
    logic sclSync_q;
    logic sclPrev_q;
    logic sdaMeta_q;
    logic sdaSync_q;
    logic sdaPrev_q;
    line_s events_d;
    line_s events_q;

    // -------------------------------------------------------------
    // two-stage synchronisers, then one history stage
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            sclPrev_q <= sclSync_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
            sdaPrev_q <= sdaSync_q;
        end
    end

    // -------------------------------------------------------------
    // event decode from synchronised samples only
    // -------------------------------------------------------------
    always_comb
    begin
        events_d.sclRise = sclSync_q && !sclPrev_q;
        events_d.sclFall = !sclSync_q && sclPrev_q;
        // sda moving while scl stays high is never data
        events_d.start = sclSync_q && sclPrev_q && sdaPrev_q
            && !sdaSync_q;
        events_d.stop = sclSync_q && sclPrev_q && !sdaPrev_q
            && sdaSync_q;
        events_d.sda = sdaSync_q;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            events_q <= '0;
        else
            events_q <= events_d;
    end

    assign events = events_q;

endmodule

`default_nettype wire

// >>> cmd_fifo.sv
// small first-in first-out buffer with registered output stage
// assumes one writer and one reader on clk
`timescale 1ns/1ns
`default_nettype none

module cmd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic [WIDTH-1:0] outData_q;
    logic outValid_q;
    logic doWrite;
    logic doLoad;

    assign inReady = (count_q != CW'(DEPTH));
    assign doWrite = inValid && inReady;
    // refill the output stage when empty or being drained
    assign doLoad = (count_q != '0) && (!outValid_q || outReady);

    always_ff @(posedge clk)
    begin
        if (doWrite)
            mem_q[wrPtr_q] <= inData;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (doWrite)
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            if (doLoad)
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            if (doWrite && !doLoad)
                count_q <= count_q + 1'b1;
            else if (!doWrite && doLoad)
                count_q <= count_q - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            outValid_q <= 1'b0;
            outData_q <= '0;
        end
        else if (doLoad)
        begin
            outValid_q <= 1'b1;
            outData_q <= mem_q[rdPtr_q];
        end
        else if (outReady)
            outValid_q <= 1'b0;
    end

    assign outData = outData_q;
    assign outValid = outValid_q;

endmodule

`default_nettype wire

// >>> pot_i2c_slave.sv
// two-wire slave front end of a dual potentiometer with stored settings
// assumes a 10 MHz clk, open-drain sda resolved outside, scl from master
//
// Overview of operation
// - sda change with scl high is start/stop
// - start is sda fall, scl high; wait for it
// - stop is sda rise, scl high; ends transaction
// - address byte: type nibble plus four straps
// - acknowledge matching address, otherwise stay silent
// - receiver pulls sda low on ninth clock
// - acknowledge written bytes after address; a full buffer withholds the one ending a command
// - read: send eight bits, sample master acknowledge
// - no master acknowledge: release, wait for stop
// - write is address, instruction, data, then stop
// - decode opcode, register and wiper selections
// - stop after stored-register write starts programming
// - programming: sda released, no acknowledge, deaf
// - programming lasts at most five milliseconds
// - polling address gets acknowledge only when idle
// - opcode bits 7-4, wiper bit, two register bits
`timescale 1ns/1ns
`default_nettype none

module pot_i2c_slave
    import pot_pkg::*;
#(
    parameter int WR_CYCLES = `WR_CYCLES,
    // device type nibble; value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'hA
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrStrapBit0,
    input wire logic addrStrapBit1,
    input wire logic addrStrapBit2,
    input wire logic addrStrapBit3,
    output cmd_s readSel,
    input wire logic [7:0] txByte,
    output cmd_s cmdData,
    output logic cmdValid,
    input wire logic cmdReady,
    output logic nvBusy
);

    localparam logic [`WR_CNT_BITS-1:0] WR_LAST =
        `WR_CNT_BITS'(WR_CYCLES - 1);

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    line_s ev;
    state_e state_q;
    state_e state_d;
    logic [7:0] shift_q;
    logic [2:0] bitCnt_q;
    logic byteDone_q;
    logic masterAck_q;
    cmd_s cur_q;
    cmd_s instrWord;
    cmd_s pushWord;
    cmd_s push_q;
    logic pushValid_q;
    logic nvPending_q;
    logic [`WR_CNT_BITS-1:0] wrCnt_q;
    logic sdaOe_q;
    logic sdaOut_q;
    logic nvBusy_q;
    logic fifoReady;
    logic [3:0] strap;
    logic addrMatch;
    logic wrDone;
    logic driveAck;
    logic loadTx;
    logic shiftTx;
    logic releaseNow;
    logic pushNow;
    logic setNv;
    logic latchCmd;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic isRead(input logic [3:0] op);
        isRead = (op == `OP_RD_WCR) || (op == `OP_RD_DR);
    endfunction

    function automatic logic needsData(input logic [3:0] op);
        needsData = (op == `OP_WR_WCR) || (op == `OP_WR_DR);
    endfunction

    function automatic logic nvTarget(input logic [3:0] op);
        nvTarget = (op == `OP_WR_DR) || (op == `OP_XFR_W2D)
            || (op == `OP_GXFR_W2D);
    endfunction

    assign strap = {addrStrapBit3, addrStrapBit2, addrStrapBit1,
        addrStrapBit0};
    assign addrMatch =
        (shift_q[`ADDR_TYPE_HI:`ADDR_TYPE_LO] == DEV_TYPE)
        && (shift_q[`ADDR_STRAP_HI:`ADDR_STRAP_LO] == strap);
    assign wrDone = (wrCnt_q == WR_LAST);

    always_comb
    begin
        instrWord = '0;
        instrWord.opcode = shift_q[`INSTR_OP_HI:`INSTR_OP_LO];
        instrWord.wiperSelectBit = shift_q[`INSTR_WIPER_BIT];
        instrWord.dataRegSelectHi = shift_q[`INSTR_REG_HI];
        instrWord.dataRegSelectLo = shift_q[`INSTR_REG_LO];
    end

    // -------------------------------------------------------------
    // pin conditioning and command buffer
    // -------------------------------------------------------------
    line_sync lineSync (
        .clk(clk),
        .resetn(resetn),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .events(ev)
    );

    // a full buffer withholds the acknowledge and the command is dropped
    cmd_fifo #(
        .WIDTH($bits(cmd_s)),
        .DEPTH(`CMD_FIFO_DEPTH)
    ) cmdFifo (
        .clk(clk),
        .resetn(resetn),
        .inData(push_q),
        .inValid(pushValid_q),
        .inReady(fifoReady),
        .outData(cmdData),
        .outValid(cmdValid),
        .outReady(cmdReady)
    );

    // -------------------------------------------------------------
    // sequence control
    // -------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        driveAck = 1'b0;
        loadTx = 1'b0;
        shiftTx = 1'b0;
        releaseNow = 1'b0;
        pushNow = 1'b0;
        pushWord = cur_q;
        setNv = 1'b0;
        latchCmd = 1'b0;
        if (state_q == ST_NV_BUSY)
        begin
            // bus ignored entirely until programming ends
            if (wrDone)
                state_d = ST_IDLE;
        end
        else if (ev.stop)
        begin
            releaseNow = 1'b1;
            state_d = nvPending_q ? ST_NV_BUSY : ST_IDLE;
        end
        else if (ev.start)
        begin
            releaseNow = 1'b1;
            state_d = ST_ADDR;
        end
        else if (ev.sclFall)
        begin
            unique case (state_q)
                ST_IDLE, ST_WAIT_STOP:
                    state_d = state_q;
                ST_ADDR:
                    if (byteDone_q)
                    begin
                        if (addrMatch)
                        begin
                            driveAck = 1'b1;
                            state_d = ST_ADDR_ACK;
                        end
                        else
                            state_d = ST_WAIT_STOP;
                    end
                ST_ADDR_ACK:
                begin
                    releaseNow = 1'b1;
                    state_d = ST_INSTR;
                end
                ST_INSTR:
                    if (byteDone_q)
                    begin
                        latchCmd = 1'b1;
                        pushWord = instrWord;
                        if (isRead(instrWord.opcode)
                            || needsData(instrWord.opcode))
                        begin
                            driveAck = 1'b1;
                            state_d = ST_INSTR_ACK;
                        end
                        else if (fifoReady)
                        begin
                            driveAck = 1'b1;
                            pushNow = 1'b1;
                            setNv = nvTarget(instrWord.opcode);
                            state_d = ST_INSTR_ACK;
                        end
                        else
                            state_d = ST_WAIT_STOP;
                    end
                ST_INSTR_ACK:
                begin
                    releaseNow = 1'b1;
                    if (isRead(cur_q.opcode))
                    begin
                        loadTx = 1'b1;
                        state_d = ST_TX;
                    end
                    else if (needsData(cur_q.opcode))
                        state_d = ST_DATA;
                    else
                        state_d = ST_WAIT_STOP;
                end
                ST_DATA:
                    if (byteDone_q)
                    begin
                        if (fifoReady)
                        begin
                            driveAck = 1'b1;
                            pushNow = 1'b1;
                            pushWord.hasData = 1'b1;
                            pushWord.data = shift_q;
                            setNv = nvTarget(cur_q.opcode);
                            state_d = ST_DATA_ACK;
                        end
                        else
                            state_d = ST_WAIT_STOP;
                    end
                ST_DATA_ACK:
                begin
                    releaseNow = 1'b1;
                    state_d = ST_WAIT_STOP;
                end
                ST_TX:
                    if (byteDone_q)
                    begin
                        releaseNow = 1'b1;
                        state_d = ST_TX_ACK;
                    end
                    else
                        shiftTx = 1'b1;
                ST_TX_ACK:
                    if (masterAck_q)
                    begin
                        loadTx = 1'b1;
                        state_d = ST_TX;
                    end
                    else
                        state_d = ST_WAIT_STOP;
                ST_NV_BUSY:
                    state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // -------------------------------------------------------------
    // bit shifting and byte framing
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bitCnt_q <= 3'h0;
            byteDone_q <= 1'b0;
        end
        else if (ev.start || ev.stop || state_q == ST_NV_BUSY)
        begin
            bitCnt_q <= 3'h0;
            byteDone_q <= 1'b0;
        end
        else if (ev.sclRise && (state_q == ST_ADDR || state_q == ST_INSTR
            || state_q == ST_DATA || state_q == ST_TX))
        begin
            // three bits wrap back to zero after the eighth bit
            bitCnt_q <= bitCnt_q + 1'b1;
            if (bitCnt_q == 3'h7)
                byteDone_q <= 1'b1;
        end
        else if (ev.sclFall)
            byteDone_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            shift_q <= 8'h00;
        else if (loadTx)
            shift_q <= txByte;
        else if (shiftTx)
            shift_q <= {shift_q[6:0], 1'b0};
        else if (ev.sclRise && (state_q == ST_ADDR || state_q == ST_INSTR
            || state_q == ST_DATA))
            shift_q <= {shift_q[6:0], ev.sda};
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            masterAck_q <= 1'b0;
        else if (ev.sclRise && state_q == ST_TX_ACK)
            masterAck_q <= !ev.sda;
    end

    // -------------------------------------------------------------
    // open-drain data pin
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sdaOe_q <= 1'b0;
            sdaOut_q <= 1'b0;
        end
        else if (driveAck)
            sdaOe_q <= 1'b1;
        else if (loadTx)
            sdaOe_q <= !txByte[7];
        else if (shiftTx)
            sdaOe_q <= !shift_q[6];
        else if (releaseNow || state_d == ST_NV_BUSY)
            sdaOe_q <= 1'b0;
    end

    // -------------------------------------------------------------
    // command capture and hand-off
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
            cur_q <= '0;
        else if (latchCmd)
            cur_q <= instrWord;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pushValid_q <= 1'b0;
            push_q <= '0;
        end
        else
        begin
            pushValid_q <= pushNow;
            if (pushNow)
                push_q <= pushWord;
        end
    end

    // -------------------------------------------------------------
    // stored-setting programming cycle
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
            nvPending_q <= 1'b0;
        else if (setNv)
            nvPending_q <= 1'b1;
        else if (state_d == ST_NV_BUSY)
            nvPending_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            wrCnt_q <= '0;
        else if (state_q == ST_NV_BUSY && !wrDone)
            wrCnt_q <= wrCnt_q + 1'b1;
        else
            wrCnt_q <= '0;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            nvBusy_q <= 1'b0;
        else
            nvBusy_q <= (state_d == ST_NV_BUSY);
    end

    assign sdaOe = sdaOe_q;
    assign sdaOut = sdaOut_q;
    assign nvBusy = nvBusy_q;
    assign readSel = cur_q;

endmodule

`default_nettype wire

// >>> pot_i2c_slave_sva.sv
// assertions on the ports of the potentiometer serial slave
// assumes a bind onto pot_i2c_slave from the bench top
`timescale 1ns/1ns
`default_nettype none

module pot_i2c_slave_sva
    import pot_pkg::*;
#(
    parameter int WR_CYCLES = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire cmd_s readSel,
    input wire cmd_s cmdData,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic nvBusy
);
    // ----
    // helper: length of the programming cycle
    // ----
    logic [15:0] busyCnt_q;
    always_ff @(posedge clk)
    begin
        if (!resetn || !nvBusy)
            busyCnt_q <= 16'h0000;
        else
            busyCnt_q <= busyCnt_q + 16'h0001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence held_s;
        cmdValid && !cmdReady;
    endsequence

    // ----
    // properties
    // ----
    rst_quiet_a: assert property (disable iff (1'b0)
        !resetn |=> !sdaOe && !cmdValid && !nvBusy && readSel == 16'h0000)
        else $error("outputs active after reset");
    open_drain_a: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
    low_edge_a: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("sda moved while scl high");
    ack_stands_a: assert property ($rose(sdaOe) |=> sdaOe [*8])
        else $error("sda pull too short");
    busy_free_a: assert property (nvBusy |-> !sdaOe)
        else $error("sda pulled during programming");
    busy_stop_a: assert property ($rose(nvBusy) |-> sclIn && sdaIn)
        else $error("programming began outside a stop");
    busy_len_a: assert property (busyCnt_q <= WR_CYCLES)
        else $error("programming too long");
    cmd_hold_a: assert property (held_s |=> cmdValid && $stable(cmdData))
        else $error("command changed before accept");
endmodule

`default_nettype wire

// >>> bus_master_model.sv
// two-wire bus master: drives scl and its share of sda
// assumes sda resolved by the bench with a pull-up
`timescale 1ns/1ns
`default_nettype none

module bus_master_model #(
    parameter int QTR = 6
) (
    input wire logic clk,
    input wire logic sdaLine,
    output var logic scl,
    output var logic sdaDrv
);
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // may be called with scl low after a bare byte; both lines are raised first; we own the clock
    task automatic start();
        sdaDrv <= 1'b1;
        scl <= 1'b1;
        tick(QTR);
        sdaDrv <= 1'b0;
        tick(QTR);
        scl <= 1'b0;
        tick(QTR);
    endtask

    task automatic stop();
        sdaDrv <= 1'b0;
        tick(QTR);
        scl <= 1'b1;
        tick(QTR);
        sdaDrv <= 1'b1;
        tick(QTR);
    endtask

    // data moves only with scl low, sampled late in the high
    task automatic bitx(input logic b, output logic r);
        sdaDrv <= b;
        tick(QTR);
        scl <= 1'b1;
        tick(2 * QTR);
        r = sdaLine;
        scl <= 1'b0;
        tick(QTR);
    endtask

    // ninth clock: m low acknowledges a byte we read
    task automatic xfer(input logic [7:0] d, input logic m,
        output logic [7:0] r, output logic a);
        logic t;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], t);
            r[i] = t;
        end
        bitx(m, a);
    endtask
endmodule

`default_nettype wire

// >>> i2c_pot_slave_interface_test.sv
// self-checking bench for the potentiometer serial slave
// assumes package, master model and checker compiled first
`timescale 1ns/1ns
`default_nettype none

module i2c_pot_slave_interface_test;
    import pot_pkg::*;
    localparam int WR = 400;
    // device type nibble; value is arbitrary
    localparam logic [3:0] DEV = 4'hA;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cmdReady = 1'b0;
    logic [3:0] straps = 4'h6;
    logic [7:0] txByte = 8'h00;
    logic scl, sdaDrv, sdaOut, sdaOe, cmdValid, nvBusy, a;
    cmd_s readSel, cmdData;
    logic [7:0] r, me;
    logic [7:0] ops [3] = '{8'hD5, 8'h13, 8'h24};
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    // pull-up: low when either side pulls
    wire sdaIn = sdaDrv & ~sdaOe;
    assign me = {DEV, straps};

    always #50 clk = ~clk;

    bus_master_model u_master (.clk(clk), .sdaLine(sdaIn), .scl(scl),
        .sdaDrv(sdaDrv));
    pot_i2c_slave #(.WR_CYCLES(WR), .DEV_TYPE(DEV)) u_dut (.clk(clk),
        .resetn(resetn), .sclIn(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrStrapBit0(straps[0]),
        .addrStrapBit1(straps[1]), .addrStrapBit2(straps[2]),
        .addrStrapBit3(straps[3]), .readSel(readSel), .txByte(txByte),
        .cmdData(cmdData), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .nvBusy(nvBusy));

    task automatic test_done();
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            failures = failures + 1;
            test_done();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] d, input logic ack);
        u_master.xfer(d, 1'b1, r, a);
        chk(16'(a), ack ? 16'h0000 : 16'h0001);
    endtask

    // ----
    // scenarios
    // ----
    task automatic pop(input logic [15:0] exp);
        int n;
        n = 0;
        // let the previous pop settle before looking at the output stage
        @(posedge clk);
        while (cmdValid !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        chk(cmdData, exp);
        cmdReady <= 1'b1;
        @(posedge clk);
        cmdReady <= 1'b0;
    endtask

    task automatic poll(input logic ack);
        u_master.start();
        send(me, ack);
        u_master.stop();
    endtask

    task automatic t_write(input logic [7:0] ins, input logic [7:0] d,
        input logic dat, input logic busy);
        int n;
        u_master.start();
        send(me, 1'b1);
        send(ins, 1'b1);
        if (dat)
            send(d, 1'b1);
        u_master.stop();
        pop({ins[7:4], ins[2:0], dat, dat ? d : 8'h00});
        chk(16'(nvBusy), 16'(busy));
        if (busy)
        begin
            poll(1'b0);
            n = 0;
            while (nvBusy === 1'b1 && n < 2 * WR)
            begin
                @(posedge clk);
                n++;
            end
            poll(1'b1);
        end
    endtask

    task automatic t_read(input logic [7:0] ins, input logic [7:0] tx);
        txByte <= tx;
        u_master.start();
        send(me, 1'b1);
        send(ins, 1'b1);
        chk(readSel, {ins[7:4], ins[2:0], 9'h000});
        u_master.xfer(8'hFF, 1'b0, r, a);
        chk(16'(r), 16'(tx));
        u_master.xfer(8'hFF, 1'b1, r, a);
        chk(16'(r), 16'(tx));
        u_master.xfer(8'hFF, 1'b1, r, a);
        chk(16'(r), 16'h00FF);
        u_master.stop();
    endtask

    task automatic t_mis();
        u_master.start();
        send({4'h3, straps}, 1'b0);
        send(8'hC0, 1'b0);
        u_master.stop();
        u_master.start();
        send({DEV, ~straps}, 1'b0);
        u_master.stop();
        chk(16'(cmdValid), 16'h0000);
    endtask

    // full queue must back-pressure by withholding the ack
    task automatic t_fill();
        straps <= 4'h9;
        for (int i = 0; i < 10; i++)
        begin
            u_master.start();
            send(me, 1'b1);
            send(ops[i % 3], i < 9);
            u_master.stop();
        end
        for (int i = 0; i < 9; i++)
            pop({ops[i % 3][7:4], ops[i % 3][2:0], 9'h000});
        @(posedge clk);
        chk(16'(cmdValid), 16'h0000);
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // one millisecond of power-up wait at 100 ns per clock
        repeat (10000) @(posedge clk);
        send(me, 1'b0);
        t_write(8'hC5, 8'h3C, 1'b1, 1'b1);
        t_write(8'hA4, 8'h5A, 1'b1, 1'b0);
        t_write(8'hE6, 8'h00, 1'b0, 1'b1);
        t_write(8'h81, 8'h00, 1'b0, 1'b1);
        t_read(8'h94, 8'hA5);
        t_read(8'hBB, 8'h3C);
        t_mis();
        t_fill();
        test_done();
    end
endmodule

bind pot_i2c_slave pot_i2c_slave_sva #(.WR_CYCLES(WR_CYCLES)) u_sva (
    .clk(clk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .readSel(readSel), .cmdData(cmdData),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .nvBusy(nvBusy));

`default_nettype wire
